// [logic/sniff_rate_pkg.sv]
// Shared constants, tables and types for the sniff and standby rate selector
`default_nettype none
package sniff_rate_pkg;

    // ********************************************
    // Register indices and byte addresses
    // ********************************************
    localparam logic [7:0] RATE1_IDX = 8'h11;   // Wake rate and manual select
    localparam logic [7:0] WATCH_IDX = 8'h12;   // Activity-watch rate control
    localparam logic [7:0] MODE_IDX = 8'h1c;    // Power mode mirror
    localparam logic [7:0] SHADOW_IDX = 8'h29;  // Shadow data window
    localparam logic [7:0] RATE1_ADDR = 8'(RATE1_IDX << 2);
    localparam logic [7:0] WATCH_ADDR = 8'(WATCH_IDX << 2);
    localparam logic [7:0] MODE_ADDR = 8'(MODE_IDX << 2);
    localparam logic [7:0] SHADOW_ADDR = 8'(SHADOW_IDX << 2);

    // ********************************************
    // Field positions and reset values
    // ********************************************
    localparam int WATCH_LSB = 0;      // Watch rate code [3:0]
    localparam int FIXED_ZERO_BIT = 4; // Always zero, host writes zero
    localparam int STANDBY_LSB = 5;    // Standby rate code [7:5]
    localparam int WAKE_LSB = 0;       // Wake rate code [3:0]
    localparam int MANUAL_LSB = 4;     // Manual select [6:4]
    localparam int MODE_LSB = 4;       // Power mode [6:4]
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    localparam logic [2:0] MANUAL_OFF = 3'h0;  // Manual rate mode disabled

    // ********************************************
    // Power mode codes and trigger threshold
    // ********************************************
    localparam logic [2:0] MODE_ULP = 3'h3;    // Ultra-low power column
    localparam logic [2:0] MODE_LP = 3'h0;     // Low power column
    localparam logic [2:0] MODE_PREC = 3'h4;   // Precision column
    localparam logic [7:0] TRIG_MIN = 8'h01;   // Rates hold above this count
    localparam logic [15:0] RATE_NA = 16'h0000;  // Unavailable rate

    // ********************************************
    // Rate tables, tenths of Hz, {ulp, lp, precision}
    // ********************************************
    localparam logic [47:0] WATCH_TABLE [16] = '{
        48'h003c_0046_0046, 48'h0004_0004_0002,
        48'h0008_0008_0004, 48'h000f_000f_0009,
        48'h003c_0046_0046, 48'h0082_008c_008c,
        48'h00fa_0118_0118, 48'h01f4_021c_0226,
        48'h03e8_041a_0320, 48'h076c_0834_0000,
        48'h0ed8_0fa0_0000, 48'h1d4c_1770_0000,
        48'h2af8_0000_0000, 48'h0000_0000_0000,
        48'h0000_0000_0000, 48'h32c8_1d4c_03e8
    };
    localparam logic [47:0] STANDBY_TABLE [8] = '{
        48'h000a_0005_0001, 48'h001e_000a_0002,
        48'h0032_001e_0004, 48'h0064_003c_0008,
        48'h00e6_0078_000f, 48'h01c2_00f0_001e,
        48'h0384_01e0_0032, 48'h0708_03e8_0064
    };

    // Register selected by an APB address
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_RATE1,
        SEL_WATCH,
        SEL_MODE,
        SEL_SHADOW
    } reg_sel_t;

endpackage : sniff_rate_pkg
`default_nettype wire

// [logic/shadow_byte_store.sv]
// Small byte memory holding the manual-rate shadow registers
`timescale 1ns/100ps
`default_nettype none
module shadow_byte_store #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    // ********************************************
    // Storage
    // ********************************************
    logic [WIDTH-1:0] mem [DEPTH];  // No reset, contents undefined
    logic [WIDTH-1:0] next_rdata;   // Read data to register

    // Read port, registered so the bus sees a stable byte
    always_comb
    begin
        next_rdata = mem[raddr];
    end

    // Write port only; the read register has its own block below
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    // Read register reset to zero; after reset it follows the unreset memory
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata <= '0;
        end
        else
        begin
            rdata <= next_rdata;
        end
    end

endmodule : shadow_byte_store
`default_nettype wire

// [logic/sniff_standby_rate_select.sv]
// APB register block resolving activity-watch and standby rate codes
`timescale 1ns/100ps
`default_nettype none
module sniff_standby_rate_select #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [7:0] trigger_count,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [3:0] watch_rate_code,
    output logic [2:0] standby_rate_code,
    output logic [15:0] watch_rate_dhz,
    output logic [15:0] standby_rate_dhz,
    output logic watch_rate_ok,
    output logic mode_ok,
    output logic rates_in_force,
    output logic manual_rate_active
);

    // Bus timing in short: setup, access, one wait state, answer
    // A write lands on the edge that sees pready high, so a master
    // that gives up early never changes a register
    // Every output is a flop; nothing combinational reaches a pin

    // ********************************************
    // Helper functions
    // ********************************************
    // Both are pure decoders with no state of their own

    // The four addresses are distinct, so the case is unique
    // Address to register; upper address bits must be zero
    function automatic sniff_rate_pkg::reg_sel_t decode(
        input logic [ADDR_W-1:0] addr
    );
        logic [7:0] low;
        low = addr[7:0];
        decode = sniff_rate_pkg::SEL_NONE;
        // A wider bus aliases nothing; upper bits miss every register
        if ((addr >> 8) == '0)
        begin
            unique case (low)
                sniff_rate_pkg::RATE1_ADDR: decode = sniff_rate_pkg::SEL_RATE1;
                sniff_rate_pkg::WATCH_ADDR: decode = sniff_rate_pkg::SEL_WATCH;
                sniff_rate_pkg::MODE_ADDR: decode = sniff_rate_pkg::SEL_MODE;
                sniff_rate_pkg::SHADOW_ADDR: decode = sniff_rate_pkg::SEL_SHADOW;
                default: decode = sniff_rate_pkg::SEL_NONE;
            endcase
        end
    endfunction : decode

    // Rows pack three columns, ultra-low power in the top slice
    // An unknown mode falls back to low power and is flagged apart
    // Pick the rate column for a power mode
    function automatic logic [15:0] pick_column(
        input logic [47:0] row,
        input logic [2:0] mode
    );
        pick_column = row[31:16];  // Low power as fallback
        if (mode == sniff_rate_pkg::MODE_ULP)
        begin
            pick_column = row[47:32];
        end
        else if (mode == sniff_rate_pkg::MODE_PREC)
        begin
            pick_column = row[15:0];
        end
    endfunction : pick_column

    // ********************************************
    // Register state
    // ********************************************
    logic [3:0] wake_rate_code;        // Stored only, used elsewhere
    logic [2:0] manual_shadow_select;  // Shadow byte selector
    logic [2:0] power_mode;            // Power mode column select
    // Next values, all settled by the bus process below
    logic [3:0] next_watch_rate_code;
    logic [2:0] next_standby_rate_code;
    logic [3:0] next_wake_rate_code;
    logic [2:0] next_manual_shadow_select;
    logic [2:0] next_power_mode;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    // Bus decode and strobes
    sniff_rate_pkg::reg_sel_t sel;     // Decoded target
    logic access;                      // Access phase, not yet answered
    logic commit;                      // Completing edge of a transfer
    logic shadow_we;                   // Shadow byte write strobe
    logic [7:0] shadow_rdata;          // Registered shadow byte

    // One select addresses both ports, so a read always shows
    // the byte that the next write would replace
    // Shadow registers behind the manual select window
    shadow_byte_store #(
        .WIDTH(8),
        .DEPTH(8),
        .AW(3)
    ) u_shadow (
        .clk(pclk),
        .rst_n(presetn),
        .we(shadow_we),
        .waddr(manual_shadow_select),
        .wdata(pwdata[7:0]),
        .raddr(manual_shadow_select),
        .rdata(shadow_rdata)
    );

    // ********************************************
    // APB slave and register file
    // ********************************************

    // One wait state per transfer gives the shadow read time to settle
    always_comb
    begin
        sel = decode(paddr);
        access = psel && penable && !pready;
        commit = psel && penable && pready;
        next_pready = access;
        next_pslverr = access && (sel == sniff_rate_pkg::SEL_NONE);
        // Read data idles at zero; fields hold unless a write completes
        next_prdata = sniff_rate_pkg::RDATA_RESET;
        next_watch_rate_code = watch_rate_code;
        next_standby_rate_code = standby_rate_code;
        next_wake_rate_code = wake_rate_code;
        next_manual_shadow_select = manual_shadow_select;
        next_power_mode = power_mode;
        shadow_we = 1'b0;
        // Captured on the access edge so it stands with pready
        // Read data; bit 4 of the watch register always reads zero
        if (access && !pwrite)
        begin
            unique case (sel)
                sniff_rate_pkg::SEL_RATE1:
                begin
                    next_prdata[sniff_rate_pkg::MANUAL_LSB +: 3] = manual_shadow_select;
                    next_prdata[sniff_rate_pkg::WAKE_LSB +: 4] = wake_rate_code;
                end
                sniff_rate_pkg::SEL_WATCH:
                begin
                    next_prdata[sniff_rate_pkg::STANDBY_LSB +: 3] = standby_rate_code;
                    next_prdata[sniff_rate_pkg::WATCH_LSB +: 4] = watch_rate_code;
                end
                sniff_rate_pkg::SEL_MODE:
                begin
                    next_prdata[sniff_rate_pkg::MODE_LSB +: 3] = power_mode;
                end
                sniff_rate_pkg::SEL_SHADOW:
                begin
                    // Shadow window reads zero while manual mode is off
                    if (manual_shadow_select != sniff_rate_pkg::MANUAL_OFF)
                    begin
                        next_prdata[7:0] = shadow_rdata;
                    end
                end
                default:
                begin
                    next_prdata = sniff_rate_pkg::RDATA_RESET;  // Unmapped reads zero
                end
            endcase
        end
        // Writes land on the edge that samples pready high; low byte lane
        if (commit && pwrite && pstrb[0])
        begin
            unique case (sel)
                sniff_rate_pkg::SEL_RATE1:
                begin
                    next_manual_shadow_select = pwdata[sniff_rate_pkg::MANUAL_LSB +: 3];
                    next_wake_rate_code = pwdata[sniff_rate_pkg::WAKE_LSB +: 4];
                end
                sniff_rate_pkg::SEL_WATCH:
                begin
                    // Bit 4 has no storage, so a stray one is dropped
                    next_watch_rate_code = pwdata[sniff_rate_pkg::WATCH_LSB +: 4];
                    next_standby_rate_code = pwdata[sniff_rate_pkg::STANDBY_LSB +: 3];
                end
                sniff_rate_pkg::SEL_MODE:
                begin
                    next_power_mode = pwdata[sniff_rate_pkg::MODE_LSB +: 3];
                end
                sniff_rate_pkg::SEL_SHADOW:
                begin
                    // Select zero disables manual mode, so writes are dropped
                    shadow_we = manual_shadow_select != sniff_rate_pkg::MANUAL_OFF;
                end
                default:
                begin
                    shadow_we = 1'b0;  // Unmapped writes ignored
                end
            endcase
        end
    end

    // Fields return to their power-on value of zero
    // Bus answer and stored fields
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= sniff_rate_pkg::RDATA_RESET;
            pready <= 1'b0;
            pslverr <= 1'b0;
            watch_rate_code <= sniff_rate_pkg::REG_RESET[3:0];
            standby_rate_code <= sniff_rate_pkg::REG_RESET[2:0];
            wake_rate_code <= sniff_rate_pkg::REG_RESET[3:0];
            manual_shadow_select <= sniff_rate_pkg::REG_RESET[2:0];
            power_mode <= sniff_rate_pkg::REG_RESET[2:0];
        end
        else
        begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            watch_rate_code <= next_watch_rate_code;
            standby_rate_code <= next_standby_rate_code;
            wake_rate_code <= next_wake_rate_code;
            manual_shadow_select <= next_manual_shadow_select;
            power_mode <= next_power_mode;
        end
    end

    // ********************************************
    // Rate resolution
    // ********************************************
    // Registering the lookup costs one cycle of lag but keeps the
    // table multiplexer off the output pins
    // Next values of the resolved outputs
    logic [15:0] next_watch_rate_dhz;
    logic [15:0] next_standby_rate_dhz;
    logic next_watch_rate_ok;
    logic next_mode_ok;
    logic next_rates_in_force;
    logic next_manual_rate_active;

    // Table lookup one cycle behind the stored codes
    always_comb
    begin
        // Only three column codes are defined; the rest are flagged
        next_mode_ok = (power_mode == sniff_rate_pkg::MODE_ULP)
                    || (power_mode == sniff_rate_pkg::MODE_LP)
                    || (power_mode == sniff_rate_pkg::MODE_PREC);
        next_watch_rate_dhz = pick_column(
            sniff_rate_pkg::WATCH_TABLE[watch_rate_code], power_mode);
        next_standby_rate_dhz = pick_column(
            sniff_rate_pkg::STANDBY_TABLE[standby_rate_code], power_mode);
        // Unavailable codes are flagged, not corrected; software owns them
        next_watch_rate_ok = next_mode_ok
                          && (next_watch_rate_dhz != sniff_rate_pkg::RATE_NA);
        // The figures are upper bounds only once triggers exceed one
        next_rates_in_force = trigger_count > sniff_rate_pkg::TRIG_MIN;
        next_manual_rate_active = manual_shadow_select != sniff_rate_pkg::MANUAL_OFF;
    end

    // Reset shows zero rates; the first edge after it loads defaults
    // Resolved rate outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            watch_rate_dhz <= sniff_rate_pkg::RATE_NA;
            standby_rate_dhz <= sniff_rate_pkg::RATE_NA;
            watch_rate_ok <= 1'b0;
            mode_ok <= 1'b0;
            rates_in_force <= 1'b0;
            manual_rate_active <= 1'b0;
        end
        else
        begin
            watch_rate_dhz <= next_watch_rate_dhz;
            standby_rate_dhz <= next_standby_rate_dhz;
            watch_rate_ok <= next_watch_rate_ok;
            mode_ok <= next_mode_ok;
            rates_in_force <= next_rates_in_force;
            manual_rate_active <= next_manual_rate_active;
        end
    end

    // ********************************************
    // Limitations
    // ********************************************
    // Rates are approximate upper bounds in tenths of a hertz,
    // not measured figures; the oscillator sets the real pace
    // Unavailable codes are stored as written and only flagged,
    // so software reads back exactly what it programmed
    // Bit 4 has no flop; writing one there is lost, not refused
    // The wake code is only kept; the wake logic lives elsewhere
    // Shadow bytes have no reset; read one only after writing it

endmodule : sniff_standby_rate_select
`default_nettype wire

// [testbench/sniff_standby_rate_select_sva.sv]
// Concurrent checks on the ports of the rate selector
`timescale 1ns/100ps
`default_nettype none
module sniff_standby_rate_select_sva #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [7:0] trigger_count,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] watch_rate_code,
    input wire logic [2:0] standby_rate_code,
    input wire logic [15:0] watch_rate_dhz,
    input wire logic [15:0] standby_rate_dhz,
    input wire logic watch_rate_ok,
    input wire logic mode_ok,
    input wire logic rates_in_force,
    input wire logic manual_rate_active
);
    // ********************************************
    // Helpers
    // ********************************************
    logic done_w; // Write completing at this edge
    logic mapped; // Address hits a register
    assign done_w = psel && penable && pready && pwrite && pstrb[0];
    assign mapped = paddr inside {ADDR_W'(sniff_rate_pkg::RATE1_ADDR), ADDR_W'(sniff_rate_pkg::WATCH_ADDR),
        ADDR_W'(sniff_rate_pkg::MODE_ADDR), ADDR_W'(sniff_rate_pkg::SHADOW_ADDR)};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ********************************************
    // Assertions
    // ********************************************
    // Codes are given two edges so either register layout passes
    a_watch_code: assert property (done_w && paddr == ADDR_W'(sniff_rate_pkg::WATCH_ADDR)
        |-> ##2 watch_rate_code == $past(pwdata[3:0], 2)) else $error("watch code not stored");
    a_standby_code: assert property (done_w && paddr == ADDR_W'(sniff_rate_pkg::WATCH_ADDR)
        |-> ##2 standby_rate_code == $past(pwdata[7:5], 2)) else $error("standby code not stored");
    a_mode_valid: assert property (done_w && paddr == ADDR_W'(sniff_rate_pkg::MODE_ADDR)
        |-> ##3 mode_ok == ($past(pwdata[6:4], 3) inside {3'h3, 3'h0, 3'h4})) else $error("mode flag wrong");
    a_ok_needs_mode: assert property (!mode_ok |-> !watch_rate_ok)
        else $error("watch ok without valid mode");
    a_na_rate_zero: assert property (mode_ok |-> watch_rate_ok == (watch_rate_dhz != 16'h0000))
        else $error("watch ok disagrees with rate");
    a_trig_force: assert property ($past(presetn) |-> rates_in_force == ($past(trigger_count) > 8'h01))
        else $error("rates in force wrong");
    a_answer_err: assert property (psel && penable && !pready |=> pready && pslverr == !$past(mapped))
        else $error("answer or error wrong");
    a_ready_pulse: assert property (pready |=> !pready && prdata == 32'h0000_0000)
        else $error("answer held too long");
    a_manual_flag: assert property (done_w && paddr == ADDR_W'(sniff_rate_pkg::RATE1_ADDR)
        |-> ##3 manual_rate_active == ($past(pwdata[6:4], 3) != 3'h0)) else $error("manual flag wrong");
endmodule : sniff_standby_rate_select_sva
bind sniff_standby_rate_select sniff_standby_rate_select_sva #(.ADDR_W(ADDR_W)) u_sva (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .trigger_count(trigger_count), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .watch_rate_code(watch_rate_code), .standby_rate_code(standby_rate_code), .watch_rate_dhz(watch_rate_dhz),
    .standby_rate_dhz(standby_rate_dhz), .watch_rate_ok(watch_rate_ok), .mode_ok(mode_ok),
    .rates_in_force(rates_in_force), .manual_rate_active(manual_rate_active));
`default_nettype wire

// [testbench/apb_host_model.sv]
// Host side APB master that programs the rate registers
`timescale 1ns/100ps
`default_nettype none
module apb_host_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus at time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end
    // One transfer; bit 4 of the watch register always goes out as zero
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic s,
        output logic [31:0] rd, output logic err);
        logic [7:0] dm;
        dm = (a == sniff_rate_pkg::WATCH_ADDR) ? (d & 8'hef) : d;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, dm};
        pstrb <= {3'h0, s};
        @(posedge pclk);
        penable <= 1'b1;
        // Hold until pready is seen; the bench watchdog ends a hang
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released address and data lines do not keep the last value
        paddr <= ~a;
        pwdata <= ~{24'h00_0000, dm};
    endtask : xfer
endmodule : apb_host_model
`default_nettype wire

// [testbench/sniff_standby_rate_select_tb_top.sv]
// Self-checking bench for the sniff and standby rate selector
`timescale 1ns/100ps
`default_nettype none
module sniff_standby_rate_select_tb_top;
    // Expected rates in tenths of Hz; rows keep to available codes only
    typedef struct packed {
        logic [2:0] mode;
        logic [3:0] wc;
        logic [2:0] sc;
        logic [15:0] wr;
        logic [15:0] sr;
        logic ok;
    } row_t;
    row_t rows [7] = '{'{3'h3, 4'hf, 3'h7, 16'h32c8, 16'h0708, 1'b1}, '{3'h0, 4'hf, 3'h7, 16'h1d4c, 16'h03e8, 1'b1},
        '{3'h4, 4'hf, 3'h7, 16'h03e8, 16'h0064, 1'b1}, '{3'h3, 4'hc, 3'h0, 16'h2af8, 16'h000a, 1'b1},
        '{3'h0, 4'h1, 3'h5, 16'h0004, 16'h00f0, 1'b1}, '{3'h4, 4'h8, 3'h3, 16'h0320, 16'h0008, 1'b1},
        '{3'h2, 4'h5, 3'h4, 16'h008c, 16'h0078, 1'b0}};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pslverr, pready;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, watch_rate_code;
    logic [7:0] trigger_count = 8'h00;
    logic [2:0] standby_rate_code;
    logic [15:0] watch_rate_dhz, standby_rate_dhz;
    logic watch_rate_ok, mode_ok, rates_in_force, manual_rate_active, err;
    int n_mismatch = 0;
    int checks = 0;
    always #12.5 pclk = ~pclk;
    sniff_standby_rate_select #(.ADDR_W(8)) u_sniff_standby_rate_select (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .trigger_count(trigger_count), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .watch_rate_code(watch_rate_code), .standby_rate_code(standby_rate_code),
        .watch_rate_dhz(watch_rate_dhz), .standby_rate_dhz(standby_rate_dhz), .watch_rate_ok(watch_rate_ok),
        .mode_ok(mode_ok), .rates_in_force(rates_in_force), .manual_rate_active(manual_rate_active));
    apb_host_model u_apb_host_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // Compare and count
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    // Watchdog well beyond the roughly one hundred and sixty cycles used
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        summarize();
    end
    // ********************************************
    // Main sequence
    // ********************************************
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        check("reset watch rate", 32'h46, 32'(watch_rate_dhz));
        check("reset standby rate", 32'h5, 32'(standby_rate_dhz));
        u_apb_host_model.xfer(1'b0, sniff_rate_pkg::WATCH_ADDR, 8'h00, 1'b1, rd, err);
        check("reset watch reg", 32'h0, rd);
        foreach (rows[i])
        begin
            u_apb_host_model.xfer(1'b1, sniff_rate_pkg::MODE_ADDR, {1'b0, rows[i].mode, 4'h0}, 1'b1, rd, err);
            u_apb_host_model.xfer(1'b1, sniff_rate_pkg::WATCH_ADDR, {rows[i].sc, 1'b1, rows[i].wc}, 1'b1, rd, err);
            repeat (3) @(posedge pclk);
            #1;
            check("watch rate", 32'(rows[i].wr), 32'(watch_rate_dhz));
            check("standby rate", 32'(rows[i].sr), 32'(standby_rate_dhz));
            check("watch ok", 32'(rows[i].ok), 32'(watch_rate_ok));
            check("mode ok", 32'(rows[i].ok), 32'(mode_ok));
            u_apb_host_model.xfer(1'b0, sniff_rate_pkg::WATCH_ADDR, 8'h00, 1'b1, rd, err);
            check("watch reg", {24'h0, rows[i].sc, 1'b0, rows[i].wc}, rd);
        end
        // Unmapped write and masked write leave the code alone
        u_apb_host_model.xfer(1'b1, 8'h4c, 8'h11, 1'b1, rd, err);
        check("unmapped error", 32'h1, 32'(err));
        u_apb_host_model.xfer(1'b1, sniff_rate_pkg::WATCH_ADDR, 8'h07, 1'b0, rd, err);
        repeat (2) @(posedge pclk);
        #1;
        check("watch code kept", 32'h5, 32'(watch_rate_code));
        // Trigger count threshold at one and two
        @(posedge pclk);
        trigger_count <= 8'h01;
        repeat (2) @(posedge pclk);
        #1;
        check("in force at one", 32'h0, 32'(rates_in_force));
        @(posedge pclk);
        trigger_count <= 8'h02;
        repeat (2) @(posedge pclk);
        #1;
        check("in force at two", 32'h1, 32'(rates_in_force));
        // Shadow window open, then closed by select zero
        u_apb_host_model.xfer(1'b1, sniff_rate_pkg::RATE1_ADDR, 8'h30, 1'b1, rd, err);
        u_apb_host_model.xfer(1'b0, sniff_rate_pkg::RATE1_ADDR, 8'h00, 1'b1, rd, err);
        check("rate1 reg", 32'h30, rd);
        u_apb_host_model.xfer(1'b1, sniff_rate_pkg::SHADOW_ADDR, 8'h5a, 1'b1, rd, err);
        u_apb_host_model.xfer(1'b0, sniff_rate_pkg::SHADOW_ADDR, 8'h00, 1'b1, rd, err);
        check("shadow read", 32'h5a, rd);
        check("manual active", 32'h1, 32'(manual_rate_active));
        u_apb_host_model.xfer(1'b1, sniff_rate_pkg::RATE1_ADDR, 8'h00, 1'b1, rd, err);
        u_apb_host_model.xfer(1'b0, sniff_rate_pkg::SHADOW_ADDR, 8'h00, 1'b1, rd, err);
        check("shadow closed", 32'h0, rd);
        check("manual off", 32'h0, 32'(manual_rate_active));
        // Second reset in mid-run restores defaults
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        check("rereset code", 32'h0, 32'(watch_rate_code));
        check("rereset rate", 32'h46, 32'(watch_rate_dhz));
        summarize();
    end
endmodule : sniff_standby_rate_select_tb_top
`default_nettype wire
